// *** inc/timer_pwm_consts.svh ***
`ifndef TIMER_PWM_CONSTS_SVH
`define TIMER_PWM_CONSTS_SVH

// apb register offsets
`define REG_CTRL 8'h00
`define REG_PERIOD 8'h04
`define REG_DUTY 8'h08
`define REG_CARRIER 8'h0C
`define REG_STATUS 8'h10
`define REG_COMPANION 8'h14

// control register fields
`define CTRL_RUN 0
`define CTRL_MODE 1
`define CTRL_CLK_LO 2
`define CTRL_CLK_HI 4
`define CTRL_LEVEL 5
`define CTRL_REMOTE 6
`define CTRL_COMP_RUN 7

// carrier register fields
`define CARRIER_BUF 0
`define CARRIER_ACT 1

// reset values
`define CTRL_RESET 8'h00
`define COMPARE_RESET 8'h00
`define COMPANION_RESET 8'hFF

// timing counts, in count clocks
`define DUTY_XFER_TICKS 2'h3
`define BUF_WRITE_GAP 2'h2
`define COMP_PRESCALE_MAX 3'h7

`endif

// *** inc/timer_pwm_pkg.sv ***
package timer_pwm_pkg;

   typedef enum logic {
      MODE_PWM = 1'b0,
      MODE_CARRIER = 1'b1
   } mode_e;

   typedef enum logic {
      PH_FIRST = 1'b0,
      PH_SECOND = 1'b1
   } phase_e;

endpackage

// *** inc/timer_pwm_link_if.sv ***
`timescale 1ns/1ns
interface timer_pwm_link_if;
   import timer_pwm_pkg::*;

   logic timer_run_bit;
   mode_e mode;
   logic [2:0] clk_sel;
   logic output_level_select;
   logic remote_output_enable;
   logic cmp0_wr;
   logic cmp1_wr;
   logic [7:0] wdata;
   logic buf_wr;
   logic buf_wdata;
   logic companion_period_irq;
   logic count_tick;
   logic [7:0] count;
   logic carrier_enable_buffer;
   logic carrier_enable_active;
   logic pin_level;

   modport device (
      input timer_run_bit,
      input mode,
      input clk_sel,
      input output_level_select,
      input remote_output_enable,
      input cmp0_wr,
      input cmp1_wr,
      input wdata,
      input buf_wr,
      input buf_wdata,
      input companion_period_irq,
      output count_tick,
      output count,
      output carrier_enable_buffer,
      output carrier_enable_active,
      output pin_level
   );

   modport host (
      output timer_run_bit,
      output mode,
      output clk_sel,
      output output_level_select,
      output remote_output_enable,
      output cmp0_wr,
      output cmp1_wr,
      output wdata,
      output buf_wr,
      output buf_wdata,
      output companion_period_irq,
      input count_tick,
      input count,
      input carrier_enable_buffer,
      input carrier_enable_active,
      input pin_level
   );

endinterface

// *** design/timer_pwm_device.sv ***
// Functional notes
// - mask first count clock after start, output inactive
// - duty writes accepted while counting
// - running duty write latched, moved at old match
// - transfer needs three count clocks after write
// - period match: clear, output active, interrupt
// - duty match: output inactive only
// - run cleared: no interrupt, output inactive
// - carrier mode only on carrier-capable instance
// - low width fixed while running; high width rewritable
// - remote enable and carrier enable select output
// - carrier enable as buffer and active pair
// - companion interrupt synced, copies buffer to active
// - copy at second count clock after sync
// - software spaces buffer writes two clocks apart
// - carrier: low match, interrupt, clear, go high
// - carrier: high match, interrupt, clear, go low
// - carrier reaches pin only when active enable
// - carrier period N+M+2, high M+1
// - run cleared halts the counter
// - software rewrites high width on every restart
// - count clock above six times companion clock
// - pwm period N+1, active width M+1
// - carrier compare values kept within 01h to ffh
`timescale 1ns/1ns
`include "timer_pwm_consts.svh"

module timer_pwm_device
   import timer_pwm_pkg::*;
#(
   parameter bit carrier_capable = 1'b1
)
(
   input wire logic mclk,
   input wire logic nrst,
   timer_pwm_link_if.device link,
   output logic timer_output_pin,
   output logic timer_match_irq
);

   logic [7:0] prescale;
   logic tick;
   logic running;
   logic masked;
   phase_e phase;
   logic [7:0] cnt;
   logic out_act;
   logic [7:0] period_compare;
   logic [7:0] duty_compare;
   logic [7:0] duty_latch;
   logic duty_pend;
   logic [1:0] duty_age;
   logic carrier_enable_buffer;
   logic carrier_enable_active;
   logic sync_pend;
   logic synced_period_pulse;
   logic sync_stage;
   logic carrier_gate;
   logic pin;
   logic irq;
   logic carrier_mode;
   logic counting;
   logic match_first;
   logic match_second;
   logic next_pin;

   function automatic logic tick_of(input logic [2:0] sel, input logic [7:0] pre);
      logic [7:0] mask;
      mask = (8'h01 << sel) - 8'h01;
      return (pre & mask) == mask;
   endfunction

   assign carrier_mode = carrier_capable && (link.mode == MODE_CARRIER);
   assign counting = running && link.timer_run_bit && tick && !masked;
   assign match_first = counting && (phase == PH_FIRST) && (cnt == period_compare);
   assign match_second = counting && (phase == PH_SECOND) && (cnt == duty_compare);

   // count clock from a free prescaler; registered so it is a clean one-cycle enable
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         prescale <= 8'h00;
         tick <= 1'b0;
      end
      else
      begin
         prescale <= prescale + 8'h01;
         tick <= tick_of(link.clk_sel, prescale);
      end
   end

   // counter and compare sequencing
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         running <= 1'b0;
         masked <= 1'b0;
         phase <= PH_FIRST;
         cnt <= 8'h00;
         out_act <= 1'b0;
      end
      else if (!link.timer_run_bit)
      begin
         running <= 1'b0;
         phase <= PH_FIRST;
         cnt <= 8'h00;
         out_act <= 1'b0;
      end
      else if (!running)
      begin
         running <= 1'b1;
         masked <= 1'b1;
      end
      else if (tick && masked)
      begin
         masked <= 1'b0;
      end
      else if (match_first)
      begin
         cnt <= 8'h00;
         phase <= PH_SECOND;
         out_act <= 1'b1;
      end
      else if (match_second)
      begin
         phase <= PH_FIRST;
         out_act <= 1'b0;
         cnt <= carrier_mode ? 8'h00 : cnt + 8'h01;
      end
      else if (counting)
      begin
         cnt <= cnt + 8'h01;
      end
   end

   // period match pulses the interrupt in both modes, high-width match only in carrier
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         irq <= 1'b0;
      else
         irq <= match_first || (carrier_mode && match_second);
   end

   // low width / period value only takes writes while stopped
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         period_compare <= `COMPARE_RESET;
      else if (link.cmp0_wr && !running)
         period_compare <= link.wdata;
   end

   // duty / high width: direct while stopped, latched while counting
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         duty_compare <= `COMPARE_RESET;
         duty_latch <= `COMPARE_RESET;
         duty_pend <= 1'b0;
         duty_age <= 2'h0;
      end
      else if (link.cmp1_wr && !running)
      begin
         duty_compare <= link.wdata;
         duty_pend <= 1'b0;
      end
      else if (link.cmp1_wr)
      begin
         duty_latch <= link.wdata;
         duty_pend <= 1'b1;
         duty_age <= 2'h0;
      end
      else
      begin
         if (tick && duty_pend && duty_age != `DUTY_XFER_TICKS)
            duty_age <= duty_age + 2'h1;
         // a match too soon after the write leaves the value pending for the next one
         if (match_second && duty_pend && duty_age == `DUTY_XFER_TICKS)
         begin
            duty_compare <= duty_latch;
            duty_pend <= 1'b0;
         end
      end
   end

   // carrier enable master/slave pair
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         carrier_enable_buffer <= 1'b0;
      else if (link.buf_wr)
         carrier_enable_buffer <= link.buf_wdata;
   end

   // companion event is caught sticky, so it is not lost between count clocks
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         sync_pend <= 1'b0;
         synced_period_pulse <= 1'b0;
         sync_stage <= 1'b0;
         carrier_enable_active <= 1'b0;
      end
      else
      begin
         // an event on a count clock is taken at once; holding it too would pulse twice
         if (link.companion_period_irq && !tick)
            sync_pend <= 1'b1;
         else if (tick)
            sync_pend <= 1'b0;
         if (tick)
         begin
            synced_period_pulse <= sync_pend || link.companion_period_irq;
            sync_stage <= synced_period_pulse;
            if (sync_stage)
               carrier_enable_active <= carrier_enable_buffer;
         end
      end
   end

   // gate follows the enable only while the carrier is low, keeping high widths whole
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         carrier_gate <= 1'b0;
      else if (!out_act)
         carrier_gate <= carrier_enable_active;
   end

   always_comb
   begin
      if (carrier_mode)
         next_pin = link.remote_output_enable ? (carrier_gate && out_act)
                                              : carrier_enable_active;
      else
         next_pin = out_act ^ link.output_level_select;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         pin <= 1'b0;
      else
         pin <= next_pin;
   end

   assign timer_output_pin = pin;
   assign timer_match_irq = irq;
   assign link.count_tick = tick;
   assign link.count = cnt;
   assign link.carrier_enable_buffer = carrier_enable_buffer;
   assign link.carrier_enable_active = carrier_enable_active;
   assign link.pin_level = pin;

endmodule

// *** design/timer_pwm_host.sv ***
`timescale 1ns/1ns
`include "timer_pwm_consts.svh"

module timer_pwm_host
   import timer_pwm_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   timer_pwm_link_if.host link
);

   logic [7:0] ctrl;
   logic [7:0] low_width_compare;
   logic [7:0] high_width_compare;
   logic [7:0] comp_period;
   logic [1:0] buf_gap;
   logic [2:0] comp_prescale;
   logic [7:0] companion_counter;
   logic comp_irq;
   logic cmp0_wr;
   logic cmp1_wr;
   logic [7:0] wdata;
   logic buf_wr;
   logic buf_wdata;
   logic blocked;
   logic done;
   logic mapped;
   logic [31:0] rdata;

   function automatic logic [7:0] clamp(input logic carrier, input logic [7:0] v);
      return (carrier && v == 8'h00) ? 8'h01 : v;
   endfunction

   // carrier writes wait in the access phase until two count clocks have passed
   assign blocked = pwrite && (paddr == `REG_CARRIER) && (buf_gap < `BUF_WRITE_GAP);
   assign done = psel && penable && pready;
   assign mapped = paddr == `REG_CTRL || paddr == `REG_PERIOD || paddr == `REG_DUTY
                   || paddr == `REG_CARRIER || paddr == `REG_STATUS
                   || paddr == `REG_COMPANION;

   always_comb
   begin
      unique case (paddr)
         `REG_CTRL: rdata = {24'h00_0000, ctrl};
         `REG_PERIOD: rdata = {24'h00_0000, low_width_compare};
         `REG_DUTY: rdata = {24'h00_0000, high_width_compare};
         `REG_CARRIER: rdata = {30'h0000_0000, link.carrier_enable_active,
                                link.carrier_enable_buffer};
         `REG_STATUS: rdata = {23'h00_0000, link.pin_level, link.count};
         `REG_COMPANION: rdata = {24'h00_0000, comp_period};
         default: rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && penable && !pready && !blocked;
         pslverr <= psel && penable && !pready && !blocked && !mapped;
         if (psel && penable && !pready && !blocked)
            prdata <= pwrite ? 32'h0000_0000 : rdata;
      end
   end

   // writes land at the edge where pready is sampled high
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl <= `CTRL_RESET;
         low_width_compare <= `COMPARE_RESET;
         high_width_compare <= `COMPARE_RESET;
         comp_period <= `COMPANION_RESET;
         cmp0_wr <= 1'b0;
         cmp1_wr <= 1'b0;
         wdata <= 8'h00;
         buf_wr <= 1'b0;
         buf_wdata <= 1'b0;
      end
      else
      begin
         cmp0_wr <= 1'b0;
         cmp1_wr <= 1'b0;
         buf_wr <= 1'b0;
         if (done && pwrite)
         begin
            unique case (paddr)
               `REG_CTRL:
               begin
                  ctrl <= pwdata[7:0];
                  // restart reloads the high width from the shadow copy
                  if (pwdata[`CTRL_RUN] && !ctrl[`CTRL_RUN])
                  begin
                     cmp1_wr <= 1'b1;
                     wdata <= high_width_compare;
                  end
               end
               `REG_PERIOD:
               begin
                  if (!ctrl[`CTRL_RUN])
                  begin
                     low_width_compare <= clamp(ctrl[`CTRL_MODE], pwdata[7:0]);
                     cmp0_wr <= 1'b1;
                     wdata <= clamp(ctrl[`CTRL_MODE], pwdata[7:0]);
                  end
               end
               `REG_DUTY:
               begin
                  high_width_compare <= clamp(ctrl[`CTRL_MODE], pwdata[7:0]);
                  cmp1_wr <= 1'b1;
                  wdata <= clamp(ctrl[`CTRL_MODE], pwdata[7:0]);
               end
               `REG_CARRIER:
               begin
                  buf_wr <= 1'b1;
                  buf_wdata <= pwdata[`CARRIER_BUF];
               end
               `REG_COMPANION: comp_period <= pwdata[7:0];
               default:
               begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         buf_gap <= `BUF_WRITE_GAP;
      else if (done && pwrite && paddr == `REG_CARRIER)
         buf_gap <= 2'h0;
      else if (link.count_tick && buf_gap < `BUF_WRITE_GAP)
         buf_gap <= buf_gap + 2'h1;
   end

   // companion period timer; prescale of eight keeps its clock below a sixth
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         comp_prescale <= 3'h0;
         companion_counter <= 8'h00;
         comp_irq <= 1'b0;
      end
      else if (!ctrl[`CTRL_COMP_RUN])
      begin
         comp_prescale <= 3'h0;
         companion_counter <= 8'h00;
         comp_irq <= 1'b0;
      end
      else
      begin
         comp_irq <= 1'b0;
         if (link.count_tick)
         begin
            comp_prescale <= comp_prescale + 3'h1;
            if (comp_prescale == `COMP_PRESCALE_MAX)
            begin
               if (companion_counter == comp_period)
               begin
                  companion_counter <= 8'h00;
                  comp_irq <= 1'b1;
               end
               else
                  companion_counter <= companion_counter + 8'h01;
            end
         end
      end
   end

   assign link.timer_run_bit = ctrl[`CTRL_RUN];
   assign link.mode = mode_e'(ctrl[`CTRL_MODE]);
   assign link.clk_sel = ctrl[`CTRL_CLK_HI:`CTRL_CLK_LO];
   assign link.output_level_select = ctrl[`CTRL_LEVEL];
   assign link.remote_output_enable = ctrl[`CTRL_REMOTE];
   assign link.cmp0_wr = cmp0_wr;
   assign link.cmp1_wr = cmp1_wr;
   assign link.wdata = wdata;
   assign link.buf_wr = buf_wr;
   assign link.buf_wdata = buf_wdata;
   assign link.companion_period_irq = comp_irq;

endmodule

// *** sim/timer_pwm_properties.sv ***
`timescale 1ns/1ns

module timer_pwm_properties
   import timer_pwm_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic timer_run_bit,
   input wire mode_e mode,
   input wire logic [2:0] clk_sel,
   input wire logic output_level_select,
   input wire logic remote_output_enable,
   input wire logic cmp0_wr,
   input wire logic [7:0] wdata,
   input wire logic companion_period_irq,
   input wire logic [7:0] count,
   input wire logic carrier_enable_buffer,
   input wire logic carrier_enable_active,
   input wire logic pin_level
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   logic [7:0] period_seen;

   // only stopped writes count: running writes are refused
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         period_seen <= 8'h00;
      else if (cmp0_wr && !timer_run_bit)
         period_seen <= wdata;
   end

   chk_count_step: assert property (timer_run_bit && $past(timer_run_bit) && $changed(count)
      |-> count == $past(count) + 8'h01 || count == 8'h00)
      else $error("counter moved by other than one step or clear");
   chk_pwm_bound: assert property (mode == MODE_PWM && timer_run_bit && $changed(count)
      |-> count <= period_seen)
      else $error("pwm counter passed the period value");
   chk_stop_hold: assert property (!timer_run_bit [*3] |-> $stable(count))
      else $error("counter moved while stopped");
   chk_pwm_idle: assert property ((mode == MODE_PWM && !timer_run_bit
      && $stable(output_level_select)) [*3] |-> pin_level == output_level_select)
      else $error("pwm pin not idle while stopped");
   chk_remote_off: assert property ((mode == MODE_CARRIER && !remote_output_enable
      && $stable(carrier_enable_active)) [*2] |-> pin_level == carrier_enable_active)
      else $error("pin does not follow enable with remote output off");
   chk_gate_closed: assert property (mode == MODE_CARRIER && remote_output_enable
      && !carrier_enable_active && !pin_level ##1
      (mode == MODE_CARRIER && remote_output_enable && !carrier_enable_active)
      |-> !pin_level)
      else $error("carrier reached pin without active enable");
   chk_active_source: assert property ($changed(carrier_enable_active)
      |-> carrier_enable_active == $past(carrier_enable_buffer))
      else $error("active enable took a value other than the buffer");
   chk_sync_early: assert property (companion_period_irq && mode == MODE_CARRIER
      |=> $stable(carrier_enable_active) [*2])
      else $error("enable copied before the second count clock");
   chk_sync_late: assert property (companion_period_irq && clk_sel == 3'h0 && timer_run_bit
      && mode == MODE_CARRIER ##1 ($stable(carrier_enable_buffer) && clk_sel == 3'h0) [*6]
      |-> carrier_enable_active == carrier_enable_buffer)
      else $error("enable not copied after companion period");
   chk_low_locked: assert property (timer_run_bit |-> !cmp0_wr)
      else $error("first compare rewritten while running");

   cover property (mode == MODE_PWM && timer_run_bit && count == period_seen);
   cover property ($rose(carrier_enable_active));
   cover property (mode == MODE_CARRIER && remote_output_enable && $rose(pin_level));
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`include "timer_pwm_consts.svh"

module tb_top;
   import timer_pwm_pkg::*;
   localparam int pwm_n = 4;
   localparam int pwm_m = 1;
   localparam int new_m = 3;
   localparam int low_n = 2;
   localparam int high_m = 1;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr, timer_output_pin, timer_match_irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, rd2;
   int fail_count, comparisons, hi, per, irqs, ones;
   timer_pwm_link_if link();
   timer_pwm_host timer_pwm_host_inst (.mclk(mclk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link));
   timer_pwm_device #(.carrier_capable(1'b1)) timer_pwm_device_inst (.mclk(mclk),
      .nrst(nrst), .link(link), .timer_output_pin(timer_output_pin),
      .timer_match_irq(timer_match_irq));
   timer_pwm_properties timer_pwm_properties_inst (.mclk(mclk), .nrst(nrst),
      .timer_run_bit(link.timer_run_bit), .mode(link.mode), .clk_sel(link.clk_sel),
      .output_level_select(link.output_level_select),
      .remote_output_enable(link.remote_output_enable), .cmp0_wr(link.cmp0_wr),
      .wdata(link.wdata), .companion_period_irq(link.companion_period_irq),
      .count(link.count), .carrier_enable_buffer(link.carrier_enable_buffer),
      .carrier_enable_active(link.carrier_enable_active), .pin_level(link.pin_level));

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 200);
      r = prdata;
      e = pslverr;
      if (n >= 200)
         check(32'h0000_0000, 32'h0000_0001, "apb answer timed out");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
   endtask

   // polled read; the copy waits for the next companion period
   task automatic wait_active(input logic b);
      logic [31:0] r;
      for (int i = 0; i < 100; i++)
      begin
         rd_reg(`REG_CARRIER, r);
         if (r[`CARRIER_ACT] === b)
            break;
      end
      check({31'h0000_0000, r[`CARRIER_ACT]}, {31'h0000_0000, b}, "active enable");
   endtask

   task automatic measure(output int h, output int p, output int q);
      int n;
      logic last;
      h = 0;
      p = 0;
      q = 0;
      n = 0;
      last = 1'b1;
      while (n < 600)
      begin
         @(posedge mclk);
         n++;
         if (timer_output_pin === 1'b1 && last === 1'b0)
            break;
         last = timer_output_pin;
      end
      while (n < 600)
      begin
         p++;
         h += int'(timer_output_pin === 1'b1);
         q += int'(timer_match_irq === 1'b1);
         last = timer_output_pin;
         @(posedge mclk);
         n++;
         if (timer_output_pin === 1'b1 && last === 1'b0)
            break;
      end
   endtask

   initial
   begin
      logic e;
      fail_count = 0;
      comparisons = 0;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      rd_reg(`REG_CTRL, rd);
      check(rd, 32'h0000_0000, "control reset");
      rd_reg(`REG_COMPANION, rd);
      check(rd, {24'h00_0000, `COMPANION_RESET}, "companion reset");
      apb(1'b0, 8'h40, 32'h0000_0000, rd, e);
      check({rd[30:0], e}, 32'h0000_0001, "unmapped read");
      $display("test reset and map done");
      wr(`REG_PERIOD, pwm_n);
      wr(`REG_DUTY, pwm_m);
      wr(`REG_CTRL, 32'h0000_0001);
      measure(hi, per, irqs);
      check(32'(per), 32'(pwm_n + 1), "pwm period");
      check(32'(hi), 32'(pwm_m + 1), "pwm active width");
      check(32'(irqs), 32'd1, "pwm interrupts per period");
      wr(`REG_DUTY, new_m);
      repeat (20) @(posedge mclk);
      measure(hi, per, irqs);
      check(32'(hi), 32'(new_m + 1), "new duty width");
      check(32'(per), 32'(pwm_n + 1), "period after duty change");
      wr(`REG_CTRL, 32'h0000_0000);
      repeat (4) @(posedge mclk);
      check({30'h0000_0000, timer_output_pin, timer_match_irq}, 32'h0000_0000, "stop");
      rd_reg(`REG_STATUS, rd);
      repeat (10) @(posedge mclk);
      rd_reg(`REG_STATUS, rd2);
      check({24'h00_0000, rd2[7:0]}, {24'h00_0000, rd[7:0]}, "count halted");
      wr(`REG_CTRL, 32'h0000_0020);
      repeat (4) @(posedge mclk);
      check(32'(timer_output_pin), 32'd1, "idle level select");
      $display("test pwm done");
      wr(`REG_PERIOD, low_n);
      wr(`REG_DUTY, high_m);
      wr(`REG_COMPANION, 32'h0000_0001);
      wr(`REG_CARRIER, 32'h0000_0002);
      rd_reg(`REG_CARRIER, rd);
      check(rd, 32'h0000_0000, "active bit read only");
      for (int i = 0; i < 4; i++)
      begin
         wr(`REG_CTRL, 32'h0000_0083 | (32'(i >> 1) << `CTRL_REMOTE));
         wr(`REG_CARRIER, 32'(i & 1));
         wait_active(i[0]);
         repeat (4) @(posedge mclk);
         ones = 0;
         repeat (12)
         begin
            @(posedge mclk);
            ones += int'(timer_output_pin === 1'b1);
         end
         if (i == 3)
            check(32'(ones > 0 && ones < 12), 32'd1, "carrier on pin");
         else
            check(32'(ones), (i == 1) ? 32'd12 : 32'd0, "remote output level");
      end
      measure(hi, per, irqs);
      check(32'(per), 32'(low_n + high_m + 2), "carrier period");
      check(32'(hi), 32'(high_m + 1), "carrier high width");
      check(32'(irqs), 32'd2, "carrier interrupts per period");
      wr(`REG_CARRIER, 32'h0000_0000);
      wait_active(1'b0);
      repeat (8) @(posedge mclk);
      check(32'(timer_output_pin), 32'd0, "carrier gated off");
      $display("test carrier done");
      print_verdict();
   end

   initial
   begin
      #(8 * 40000);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end
endmodule
